// ==== verilog/pdm_pkg.sv ====
// power-down mode controller: shared constants, register map and states
// assumes a 32-bit axi4-lite slave port and a 100 MHz system clock
package pdm_pkg;

    // ========================================================================
    // register map (byte addresses, one aligned word each)
    // ========================================================================
    localparam logic [7:0] STANDBY_CONTROL_REG_ADDR = 8'h00;
    localparam logic [7:0] SYSTEM_CONTROL_REG_ADDR = 8'h04;
    localparam logic [7:0] SYSTEM_CLOCK_CONTROL_REG_ADDR = 8'h08;
    localparam logic [7:0] COMMAND_REG_ADDR = 8'h0C;
    localparam logic [7:0] STATUS_REG_ADDR = 8'h10;

    // standby control register fields
    localparam int STANDBY_ON_SLEEP_SELECT_BIT = 7;
    localparam int WWS_LSB = 4;
    localparam int WWS_W = 3;
    localparam int SBY_RSV1_BIT = 3;
    localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h08;
    // system control register fields
    localparam int ONCHIP_RAM_ENABLE_BIT = 0;
    localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h01;
    // system clock control register fields
    localparam int CDS_LSB = 0;
    localparam int CDS_W = 3;
    localparam logic [2:0] CDS_HIGH_SPEED = 3'h0;
    localparam logic [2:0] CDS_MAX = 3'h5;
    // command register: bit 0 executes the sleep instruction
    localparam int CMD_SLEEP_BIT = 0;

    // ========================================================================
    // wakeup wait codes
    // ========================================================================
    localparam logic [2:0] WWS_RESERVED = 3'h6;
    localparam logic [2:0] WWS_SHORT = 3'h7;
    localparam int WAIT_BASE_LOG2 = 13;
    localparam int WAIT_SHORT_STATES = 16;
    localparam int WAIT_CNT_W = 19;

    // bus access lengths, in bus master clock states
    localparam int MEM_ACCESS_STATES = 1;
    localparam int IO_ACCESS_STATES = 2;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PDM_RESET,
        PDM_RUN,
        PDM_SLEEP,
        PDM_SW_STANDBY,
        PDM_OSC_WAIT,
        PDM_HW_STANDBY
    } pdm_mode_e;

endpackage

// ==== verilog/pdm_ctrl.sv ====
// power-down mode controller: medium-speed, sleep, software and hardware standby
// assumes pins and cpu strobes synchronous to aclk; registers over axi4-lite
//
// Functional notes
// RULE1 - nonzero divider select enters medium speed after bus cycle
// RULE2 - bus masters clocked at phi/2 to phi/32
// RULE3 - peripherals always on undivided clock
// RULE4 - access lengths counted in divided clock states
// RULE5 - zero divider select returns to high speed
// RULE6 - sleep with standby bit clear stops cpu only
// RULE7 - enabled unmasked interrupt ends sleep
// RULE8 - wake restores previous divider setting
// RULE9 - reset pin or watchdog forces reset state
// RULE10 - sleep with standby bit set stops everything
// RULE11 - nmi or irq restarts oscillator, waits, resumes
// RULE12 - masked or transfer-engine interrupts do not wake
// RULE13 - software enables irq pin before standby
// RULE14 - reset in standby restarts clocks at once
// RULE15 - software programs wait of 8 or 2 ms
// RULE16 - hardware standby resets, tristates, keeps ram
// RULE17 - software clears ram enable before standby
// RULE18 - boot mode pins stay fixed in standby
// RULE19 - standby release with reset low oscillates
// RULE20 - reset low 10 states before standby
// RULE21 - reset low 100 ns before standby rises
// RULE22 - wait select codes give 8192 to 262144
// RULE23 - wait counter held clear until wake
module pdm_ctrl
    import pdm_pkg::*;
(
    // system clock and bus reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // supervisor pins
    input wire logic chip_rst_pin_n,
    input wire logic hardware_standby_pin_n,
    input wire logic watchdog_overflow,
    // wake sources
    input wire logic nmi_req,
    input wire logic [5:0] external_interrupt_pins,
    input wire logic [5:0] irq_enable,
    input wire logic [5:0] irq_dte_source,
    input wire logic cpu_irq_masked,
    input wire logic other_irq_req,
    // cpu bus cycle status
    input wire logic bus_cycle_end,
    // clock and mode outputs
    output logic master_clk_en,
    output logic periph_clk_en,
    output logic cpu_run,
    output logic osc_enable,
    output logic chip_reset_n,
    output logic io_port_hiz,
    output logic ram_retain,
    output logic [5:0] master_access_states,
    output logic irq_exception_start,
    output logic [2:0] mode
);

    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        pdm_mode_e mode;
        logic [7:0] sby;
        logic [7:0] sys;
        logic [2:0] cds;
        logic [2:0] cds_active;
        logic [4:0] div_cnt;
        logic [WAIT_CNT_W-1:0] wait_cnt;
        logic sleep_pending;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic wake_pulse;
    } pdm_state_s;

    pdm_state_s state_r;
    pdm_state_s state_nxt;

    // wakeup wait length for a select code, in system clock states
    function automatic logic [WAIT_CNT_W-1:0] wait_states(input logic [2:0] code);
        if (code == WWS_SHORT) begin
            wait_states = WAIT_CNT_W'(WAIT_SHORT_STATES); // see RULE22
        end else begin
            wait_states = WAIT_CNT_W'(1) << (WAIT_BASE_LOG2 + int'(code)); // see RULE22
        end
    endfunction

    // divided clock enable period mask for a divider code
    function automatic logic [4:0] div_mask(input logic [2:0] code);
        div_mask = 5'((6'h01 << code) - 6'h01);
    endfunction

    logic wake_irq;
    logic any_wake_std;
    logic wake_sleep;
    logic div_tick;

    // a masked or transfer-engine sourced pin never wakes standby
    assign wake_irq = |(external_interrupt_pins & irq_enable & ~irq_dte_source)
        & ~cpu_irq_masked; // see RULE12
    assign any_wake_std = nmi_req | wake_irq; // see RULE11
    assign wake_sleep = nmi_req | ((wake_irq | other_irq_req) & ~cpu_irq_masked); // see RULE7
    assign div_tick = (state_r.div_cnt & div_mask(state_r.cds_active)) == 5'h00;

    always_comb begin
        state_nxt = state_r;
        state_nxt.wake_pulse = 1'b0;

        // ====================================================================
        // axi4-lite slave; write addr and data may arrive in either order
        // ====================================================================
        if (s_axi_awvalid && s_axi_awready) begin
            state_nxt.aw_got = 1'b1;
            state_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_nxt.w_got = 1'b1;
            state_nxt.wdata = s_axi_wdata;
            state_nxt.wstrb = s_axi_wstrb;
        end
        if (state_r.bvalid && s_axi_bready) begin
            state_nxt.bvalid = 1'b0;
        end
        if (state_r.aw_got && state_r.w_got && !state_r.bvalid) begin
            state_nxt.aw_got = 1'b0;
            state_nxt.w_got = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = RESP_OKAY;
            unique case (state_r.awaddr)
                STANDBY_CONTROL_REG_ADDR: begin
                    if (state_r.wstrb[0]) begin
                        state_nxt.sby[STANDBY_ON_SLEEP_SELECT_BIT] = state_r.wdata[STANDBY_ON_SLEEP_SELECT_BIT];
                        state_nxt.sby[WWS_LSB +: WWS_W] = state_r.wdata[WWS_LSB +: WWS_W];
                        state_nxt.sby[SBY_RSV1_BIT] = state_r.wdata[SBY_RSV1_BIT];
                    end
                end
                SYSTEM_CONTROL_REG_ADDR: begin
                    if (state_r.wstrb[0]) begin
                        state_nxt.sys[ONCHIP_RAM_ENABLE_BIT] = state_r.wdata[ONCHIP_RAM_ENABLE_BIT];
                    end
                end
                SYSTEM_CLOCK_CONTROL_REG_ADDR: begin
                    // codes above /32 are clamped; takes effect at bus end
                    if (state_r.wstrb[0]) begin
                        state_nxt.cds = (state_r.wdata[CDS_LSB +: CDS_W] > CDS_MAX)
                            ? CDS_MAX : state_r.wdata[CDS_LSB +: CDS_W];
                    end
                end
                COMMAND_REG_ADDR: begin
                    if (state_r.wstrb[0] && state_r.wdata[CMD_SLEEP_BIT]) begin
                        state_nxt.sleep_pending = 1'b1;
                    end
                end
                STATUS_REG_ADDR: begin
                    state_nxt.bresp = RESP_SLVERR;
                end
                default: begin
                    state_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (state_r.rvalid && s_axi_rready) begin
            state_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp = RESP_OKAY;
            state_nxt.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                STANDBY_CONTROL_REG_ADDR: state_nxt.rdata[7:0] = state_r.sby;
                SYSTEM_CONTROL_REG_ADDR: state_nxt.rdata[7:0] = state_r.sys;
                SYSTEM_CLOCK_CONTROL_REG_ADDR: state_nxt.rdata[CDS_LSB +: CDS_W] = state_r.cds;
                COMMAND_REG_ADDR: state_nxt.rdata[CMD_SLEEP_BIT] = state_r.sleep_pending;
                STATUS_REG_ADDR: begin
                    state_nxt.rdata[2:0] = state_r.mode;
                    state_nxt.rdata[6:4] = state_r.cds_active;
                end
                default: state_nxt.rresp = RESP_SLVERR;
            endcase
        end

        // ====================================================================
        // clock divider, free running on the system clock
        // ====================================================================
        state_nxt.div_cnt = state_r.div_cnt + 5'h01; // see RULE2

        // ====================================================================
        // mode sequencing
        // ====================================================================
        unique case (state_r.mode)
            PDM_RESET: begin
                if (chip_rst_pin_n) begin
                    state_nxt.mode = PDM_RUN;
                end
            end
            PDM_RUN: begin
                // divider change only between bus cycles
                if (bus_cycle_end) begin
                    state_nxt.cds_active = state_r.cds; // see RULE1 RULE5
                    if (state_r.sleep_pending) begin
                        state_nxt.sleep_pending = 1'b0;
                        state_nxt.mode = state_r.sby[STANDBY_ON_SLEEP_SELECT_BIT]
                            ? PDM_SW_STANDBY : PDM_SLEEP; // see RULE6 RULE10
                    end
                end
            end
            PDM_SLEEP: begin
                if (wake_sleep) begin
                    state_nxt.mode = PDM_RUN; // see RULE7 RULE8
                    state_nxt.wake_pulse = 1'b1;
                end
            end
            PDM_SW_STANDBY: begin
                state_nxt.wait_cnt = '0; // see RULE23
                if (any_wake_std && state_r.sby[WWS_LSB +: WWS_W] != WWS_RESERVED) begin
                    state_nxt.mode = PDM_OSC_WAIT; // see RULE11
                end
            end
            PDM_OSC_WAIT: begin
                state_nxt.wait_cnt = state_r.wait_cnt + WAIT_CNT_W'(1); // see RULE23
                if (state_nxt.wait_cnt >= wait_states(state_r.sby[WWS_LSB +: WWS_W])) begin
                    state_nxt.mode = PDM_RUN; // see RULE11 RULE8
                    state_nxt.wake_pulse = 1'b1;
                    state_nxt.wait_cnt = '0;
                end
            end
            PDM_HW_STANDBY: begin
                // leaving needs reset low so the reset state holds oscillation
                state_nxt.mode = PDM_RESET; // see RULE19
            end
        endcase

        // pins override every mode; standby wins over reset
        if (!chip_rst_pin_n || watchdog_overflow) begin
            state_nxt.mode = PDM_RESET; // see RULE9 RULE14
            state_nxt.cds = CDS_HIGH_SPEED;
            state_nxt.cds_active = CDS_HIGH_SPEED;
            state_nxt.sleep_pending = 1'b0;
            state_nxt.wait_cnt = '0;
            state_nxt.wake_pulse = 1'b0;
        end
        if (!hardware_standby_pin_n) begin
            state_nxt.mode = PDM_HW_STANDBY; // see RULE16
            state_nxt.sby = STANDBY_CONTROL_RESET;
            state_nxt.sys = SYSTEM_CONTROL_RESET;
            state_nxt.cds = CDS_HIGH_SPEED;
            state_nxt.cds_active = CDS_HIGH_SPEED;
            state_nxt.sleep_pending = 1'b0;
            state_nxt.wait_cnt = '0;
            state_nxt.wake_pulse = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= '0;
            state_r.mode <= PDM_RESET;
            state_r.sby <= STANDBY_CONTROL_RESET;
            state_r.sys <= SYSTEM_CONTROL_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    assign s_axi_awready = !state_r.aw_got;
    assign s_axi_wready = !state_r.w_got;
    assign s_axi_bvalid = state_r.bvalid;
    assign s_axi_bresp = state_r.bresp;
    assign s_axi_arready = !state_r.rvalid;
    assign s_axi_rvalid = state_r.rvalid;
    assign s_axi_rresp = state_r.rresp;
    assign s_axi_rdata = state_r.rdata;

    assign master_clk_en = div_tick
        && (state_r.mode == PDM_RUN || state_r.mode == PDM_SLEEP); // see RULE2
    assign cpu_run = state_r.mode == PDM_RUN; // see RULE6
    assign periph_clk_en = state_r.mode == PDM_RUN || state_r.mode == PDM_SLEEP
        || state_r.mode == PDM_RESET; // see RULE3 RULE10
    // reset state runs the oscillator at once, so the supervisor can wait it out
    assign osc_enable = state_r.mode != PDM_SW_STANDBY
        && state_r.mode != PDM_HW_STANDBY; // see RULE14 RULE11
    assign chip_reset_n = state_r.mode != PDM_RESET && state_r.mode != PDM_HW_STANDBY;
    assign io_port_hiz = state_r.mode == PDM_HW_STANDBY; // see RULE16
    assign ram_retain = state_r.mode == PDM_HW_STANDBY;
    // memory access length only: one divided state, given in system clock states
    assign master_access_states = 6'(MEM_ACCESS_STATES) << state_r.cds_active; // see RULE4
    assign irq_exception_start = state_r.wake_pulse;
    assign mode = state_r.mode;

endmodule

// ==== test/pdm_ctrl_checker.sv ====
// port checker for the power-down mode controller
// assumes one clock domain and the mode encoding of the package
module pdm_ctrl_checker
    import pdm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins and wake sources
    input wire logic chip_rst_pin_n,
    input wire logic hardware_standby_pin_n,
    input wire logic watchdog_overflow,
    input wire logic nmi_req,
    input wire logic [5:0] external_interrupt_pins,
    input wire logic cpu_irq_masked,
    // mode outputs
    input wire logic master_clk_en,
    input wire logic periph_clk_en,
    input wire logic cpu_run,
    input wire logic osc_enable,
    input wire logic chip_reset_n,
    input wire logic io_port_hiz,
    input wire logic ram_retain,
    input wire logic [5:0] master_access_states,
    input wire logic irq_exception_start,
    input wire logic [2:0] mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire pins_idle = chip_rst_pin_n && hardware_standby_pin_n && !watchdog_overflow;

    // ====================================================================
    // sequences and properties
    sequence s_wait_done;
        mode == PDM_OSC_WAIT ##1 mode == PDM_RUN;
    endsequence
    property p_cpu_run;
        cpu_run == (mode == PDM_RUN);
    endproperty
    property p_sleep;
        mode == PDM_SLEEP |-> periph_clk_en && !cpu_run && osc_enable;
    endproperty
    property p_sw_standby;
        mode == PDM_SW_STANDBY |-> !osc_enable && !periph_clk_en && chip_reset_n;
    endproperty
    property p_sw_hold;
        mode == PDM_SW_STANDBY && pins_idle && !nmi_req && external_interrupt_pins == 6'h00
            |=> mode == PDM_SW_STANDBY;
    endproperty
    property p_hw_standby;
        !hardware_standby_pin_n |=> mode == PDM_HW_STANDBY && io_port_hiz && ram_retain
            && !chip_reset_n && !osc_enable;
    endproperty
    property p_reset_pin;
        hardware_standby_pin_n && (!chip_rst_pin_n || watchdog_overflow)
            |=> mode == PDM_RESET && !chip_reset_n && osc_enable;
    endproperty
    property p_sleep_wake;
        mode == PDM_SLEEP && pins_idle && nmi_req |=> mode == PDM_RUN && irq_exception_start;
    endproperty
    property p_sleep_masked;
        mode == PDM_SLEEP && pins_idle && !nmi_req && cpu_irq_masked |=> mode == PDM_SLEEP;
    endproperty
    property p_wait_done;
        s_wait_done |-> irq_exception_start && osc_enable;
    endproperty
    // gap check only while divide-by-4 run mode persists
    property p_div4_gap;
        master_clk_en && mode == PDM_RUN && master_access_states == 6'h04
            |=> (!master_clk_en || mode != PDM_RUN || master_access_states != 6'h04) [*3];
    endproperty

    a_cpu_run: assert property (p_cpu_run) else $error("cpu run flag wrong");
    a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
    a_sw_standby: assert property (p_sw_standby) else $error("standby outputs wrong");
    a_sw_hold: assert property (p_sw_hold) else $error("standby left idle");
    a_hw_standby: assert property (p_hw_standby) else $error("hw standby wrong");
    a_reset_pin: assert property (p_reset_pin) else $error("reset state wrong");
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake wrong");
    a_sleep_masked: assert property (p_sleep_masked) else $error("masked woke");
    a_wait_done: assert property (p_wait_done) else $error("wake pulse missing");
    a_div4_gap: assert property (p_div4_gap) else $error("divider gap wrong");
endmodule

bind pdm_ctrl pdm_ctrl_checker pdm_ctrl_checker_i (.aclk, .aresetn, .chip_rst_pin_n,
    .hardware_standby_pin_n, .watchdog_overflow, .nmi_req, .external_interrupt_pins,
    .cpu_irq_masked, .master_clk_en, .periph_clk_en, .cpu_run, .osc_enable, .chip_reset_n,
    .io_port_hiz, .ram_retain, .master_access_states, .irq_exception_start, .mode);

// ==== test/pdm_supervisor.sv ====
// model of the external reset and standby supervisor
// assumes its tasks are called from the bench, one at a time
module pdm_supervisor #(
    parameter int RST_HOLD = 20
) (
    // system clock
    input wire logic aclk,
    // supervisor pins
    output logic chip_rst_pin_n,
    output logic hardware_standby_pin_n,
    output logic watchdog_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    // boot mode pins are not modelled, so they never move in standby
    initial begin
        chip_rst_pin_n = 1'b0;
        hardware_standby_pin_n = 1'b1;
        watchdog_overflow = 1'b0;
    end
    task automatic assert_reset();
        @(posedge aclk);
        chip_rst_pin_n <= 1'b0;
    endtask
    // hold stands in for oscillator settling
    task automatic release_reset();
        repeat (RST_HOLD) @(posedge aclk);
        chip_rst_pin_n <= 1'b1;
    endtask
    task automatic hw_standby_enter();
        assert_reset();
        repeat (10) @(posedge aclk);
        hardware_standby_pin_n <= 1'b0;
    endtask
    task automatic hw_standby_leave();
        repeat (10) @(posedge aclk);
        hardware_standby_pin_n <= 1'b1;
    endtask
    task automatic watchdog_bite();
        @(posedge aclk);
        watchdog_overflow <= 1'b1;
        @(posedge aclk);
        watchdog_overflow <= 1'b0;
    endtask
endmodule

// ==== test/tb_top.sv ====
// bench for the power-down mode controller over axi4-lite
// assumes the supervisor model drives the pins
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module tb_top
    import pdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, chip_rst_pin_n, hardware_standby_pin_n, watchdog_overflow;
    logic nmi_req, cpu_irq_masked, other_irq_req, bus_cycle_end, master_clk_en;
    logic periph_clk_en, cpu_run, osc_enable, chip_reset_n, io_port_hiz, ram_retain;
    logic irq_exception_start;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [5:0] master_access_states;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] external_interrupt_pins, irq_enable, irq_dte_source;
    logic [2:0] mode;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    pdm_ctrl pdm_ctrl_i (.*);
    pdm_supervisor #(.RST_HOLD(20)) pdm_supervisor_i (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ====================================================================
    // bus and pin tasks
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int g = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            g++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && g < 50);
        `CHK(s_axi_bvalid, 1'b1)
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int g = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            g++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && g < 50);
        `CHK(s_axi_rvalid, 1'b1)
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse_bce();
        @(posedge aclk);
        bus_cycle_end <= 1'b1;
        @(posedge aclk);
        bus_cycle_end <= 1'b0;
    endtask
    task automatic sleep_cmd(input logic [31:0] sby);
        wr(STANDBY_CONTROL_REG_ADDR, sby, RESP_OKAY);
        wr(COMMAND_REG_ADDR, 32'h0000_0001, RESP_OKAY);
        pulse_bce();
        tick(1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    // ====================================================================
    // main sequence
    initial begin
        logic [5:0] prev;
        int cnt;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, nmi_req, cpu_irq_masked, other_irq_req, bus_cycle_end} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {external_interrupt_pins, irq_enable, irq_dte_source} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        pdm_supervisor_i.release_reset();
        tick(3);
        `CHK(mode, PDM_RUN)
        rd(STANDBY_CONTROL_REG_ADDR, 32'h0000_0008, RESP_OKAY);
        rd(SYSTEM_CONTROL_REG_ADDR, 32'h0000_0001, RESP_OKAY);
        rd(8'h14, 32'h0000_0000, RESP_SLVERR);
        wr(STATUS_REG_ADDR, 32'h0000_0000, RESP_SLVERR);
        $display("test registers done");
        prev = 6'h01;
        for (int c = 1; c <= 6; c++) begin
            wr(SYSTEM_CLOCK_CONTROL_REG_ADDR, 32'(c % 6), RESP_OKAY);
            tick(2);
            `CHK(master_access_states, prev)
            pulse_bce();
            tick(1);
            prev = 6'(1 << (c % 6));
            `CHK(master_access_states, prev)
            `CHK(periph_clk_en, 1'b1)
        end
        wr(SYSTEM_CLOCK_CONTROL_REG_ADDR, 32'h0000_0002, RESP_OKAY);
        pulse_bce();
        rd(STATUS_REG_ADDR, 32'h0000_0021, RESP_OKAY);
        $display("test medium speed done");
        sleep_cmd(32'h0000_0008);
        `CHK(mode, PDM_SLEEP)
        @(posedge aclk);
        cpu_irq_masked <= 1'b1;
        other_irq_req <= 1'b1;
        tick(4);
        `CHK(mode, PDM_SLEEP)
        nmi_req <= 1'b1;
        tick(1);
        `CHK(mode, PDM_RUN)
        `CHK(master_access_states, 4'h4)
        {nmi_req, cpu_irq_masked, other_irq_req} <= 3'h0;
        $display("test sleep done");
        // short wait code keeps the run brief; real parts need the ms setting
        sleep_cmd(32'h0000_00f8);
        `CHK(osc_enable, 1'b0)
        @(posedge aclk);
        irq_enable <= 6'h02;
        irq_dte_source <= 6'h02;
        external_interrupt_pins <= 6'h02;
        tick(3);
        `CHK(mode, PDM_SW_STANDBY)
        irq_dte_source <= 6'h00;
        cpu_irq_masked <= 1'b1;
        tick(3);
        `CHK(mode, PDM_SW_STANDBY)
        cpu_irq_masked <= 1'b0;
        cnt = 0;
        do begin
            tick(1);
            cnt++;
        end while (mode !== PDM_RUN && cnt < 100);
        `CHK(cnt, WAIT_SHORT_STATES + 1)
        `CHK(master_access_states, 4'h4)
        external_interrupt_pins <= 6'h00;
        $display("test software standby done");
        sleep_cmd(32'h0000_00e8);
        @(posedge aclk);
        nmi_req <= 1'b1;
        tick(5);
        `CHK(mode, PDM_SW_STANDBY)
        nmi_req <= 1'b0;
        pdm_supervisor_i.assert_reset();
        tick(1);
        `CHK(osc_enable, 1'b1)
        pdm_supervisor_i.release_reset();
        tick(3);
        `CHK(master_access_states, 4'h1)
        wr(SYSTEM_CLOCK_CONTROL_REG_ADDR, 32'h0000_0003, RESP_OKAY);
        pulse_bce();
        pdm_supervisor_i.watchdog_bite();
        tick(0);
        `CHK(mode, PDM_RESET)
        $display("test reset done");
        wr(SYSTEM_CONTROL_REG_ADDR, 32'h0000_0000, RESP_OKAY);
        pdm_supervisor_i.hw_standby_enter();
        tick(1);
        `CHK(io_port_hiz, 1'b1)
        pdm_supervisor_i.hw_standby_leave();
        tick(1);
        `CHK(mode, PDM_RESET)
        pdm_supervisor_i.release_reset();
        tick(3);
        rd(SYSTEM_CONTROL_REG_ADDR, 32'h0000_0001, RESP_OKAY);
        $display("test hardware standby done");
        results();
    end
endmodule
